// ===== logic/kwu_pkg.sv
// shared constants and types for the key wake-up block
package kwu_pkg;
    localparam int PORT_W = 8;
    localparam int NPINS  = 16;
    // register word offsets (byte addresses)
    localparam logic [7:0] OFS_H_FLAGS   = 8'h00;
    localparam logic [7:0] OFS_J_FLAGS   = 8'h04;
    localparam logic [7:0] OFS_H_POL     = 8'h08;
    localparam logic [7:0] OFS_J_POL     = 8'h0c;
    localparam logic [7:0] OFS_H_IRQ_EN  = 8'h10;
    localparam logic [7:0] OFS_J_IRQ_EN  = 8'h14;
    localparam logic [7:0] OFS_H_PINS    = 8'h18;
    localparam logic [7:0] OFS_J_PINS    = 8'h1c;
    localparam logic [7:0] OFS_FILT_STAT = 8'h20;
    // reset values
    localparam logic [7:0] RST_FLAGS  = 8'h00;
    localparam logic [7:0] RST_POL    = 8'h00;
    localparam logic [7:0] RST_IRQ_EN = 8'h00;
    // filter timing: one filter period holds three samples
    localparam int FILT_PERIOD_NS  = 300;
    localparam int CLK_PERIOD_NS   = 10;
    localparam int FILT_PERIOD_CYC = FILT_PERIOD_NS / CLK_PERIOD_NS;
    localparam int SAMPLES         = 3;
    localparam int VOTE_MIN        = 2;
    // separation of triggering edges below which pulses may merge
    localparam int MIN_PULSE_SEPARATION_NS = FILT_PERIOD_NS;

    typedef struct packed {
        logic [PORT_W-1:0] h;
        logic [PORT_W-1:0] j;
    } pin_pair_s;

    typedef enum logic [1:0] {
        FILT_IDLE  = 2'b00,
        FILT_VOTE  = 2'b01,
        FILT_HOLD  = 2'b10
    } filt_state_e;
endpackage

// ===== logic/kwu_pin_sync.sv
// three-stage synchroniser for one vector of pin inputs
`timescale 1ns/1ps
`default_nettype none
module kwu_pin_sync #(
    parameter int W = 8
) (
    // clock
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         ce_i,
    // data
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] level_o
);
    logic [W-1:0] s1, s2, s3;
    logic [W-1:0] next_level;
    logic [W-1:0] level;

    if (W < 1) begin : g_bad_width
        $error("kwu_pin_sync: W must be positive");
    end

    // a change counts once the second and third stages agree
    always_comb begin
        next_level = level;
        for (int i = 0; i < W; i++) begin
            if (s2[i] == s3[i]) begin
                next_level[i] = s3[i];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1    <= '0;
            s2    <= '0;
            s3    <= '0;
            level <= '0;
        end else if (ce_i) begin
            s1    <= async_i;
            s2    <= s1;
            s3    <= s2;
            level <= next_level;
        end
    end

    assign level_o = level;
endmodule
`default_nettype wire

// ===== logic/kwu_edge_flags.sv
// edge detect and write-one-to-clear flags for one 8-bit port
`timescale 1ns/1ps
`default_nettype none
module kwu_edge_flags #(
    parameter int W = 8
) (
    // clock
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         ce_i,
    // pin side
    input  wire logic [W-1:0] level_i,
    input  wire logic [W-1:0] pol_i,
    input  wire logic [W-1:0] gate_i,
    // software side
    input  wire logic [W-1:0] clr_i,
    output logic      [W-1:0] flags_o,
    output logic      [W-1:0] active_o
);
    logic [W-1:0] act_prev;
    logic [W-1:0] gate_prev;
    logic [W-1:0] active;
    logic [W-1:0] hit;
    logic [W-1:0] flags;
    logic [W-1:0] next_flags;

    // active level: high for rising (pol 1), low for falling (pol 0)
    assign active   = ~(level_i ^ pol_i);
    assign active_o = active;

    // a polarity change can flip the active level and so set a flag
    always_comb begin
        // gate opening while the pin is held active counts as the edge,
        // so a pulse still active as the stop filter opens the gate leaves its flag
        hit        = active & gate_i
                   & (~act_prev | ~gate_prev);
        // set wins over clear; zero bits written leave flags alone
        next_flags = (flags & ~clr_i) | hit;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            act_prev  <= '1;
            gate_prev <= '1;
            flags     <= '0;
        end else if (ce_i) begin
            act_prev  <= active;
            gate_prev <= gate_i;
            flags    <= next_flags;
        end
    end

    assign flags_o = flags;
endmodule
`default_nettype wire

// ===== logic/key_wakeup_edge_detect.sv
// key wake-up for two ports: registers, edge flags, stop filter
// Notes on behaviour
// - selected edge on pin sets its flag
// - writing one clears the flag
// - flag means edge seen; enabled flag interrupts
// - polarity 0 falling, 1 rising edge
// - polarity 0 pulls up, 1 pulls down
// - polarity change may set the flag
// - pulse filter acts only in stop mode
// - filter starts on enabled pin's trigger edge
// - two of three samples make valid trigger
// - short gap between pulses is bridged
// - one shared filter for all enabled pins
// - closely spaced pulses may merge into one
// - short isolated pulse cannot wake from stop (only its flag is filtered; stop_wake_o still follows the raw pin)
// - all sixteen pins share one interrupt
// - enable bit one allows, zero blocks interrupt
// - unclocked stop path to interrupt request
//
// Implementation choices: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module key_wakeup_edge_detect #(
    parameter int FILT_CYC = kwu_pkg::FILT_PERIOD_CYC
) (
    // clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              ce_i,
    // wishbone slave
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [7:0]        wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    output logic                   wb_err_o,
    // wake-up pins and pull control
    input  wire kwu_pkg::pin_pair_s wake_input_i,
    output kwu_pkg::pin_pair_s     pull_up_en_o,
    output kwu_pkg::pin_pair_s     pull_down_en_o,
    // power mode and interrupt
    input  wire logic              stop_mode_i,
    output logic                   irq_o,
    output logic                   stop_wake_o
);
    import kwu_pkg::*;

    if (FILT_CYC < SAMPLES) begin : g_bad_filt
        $error("FILT_CYC below sample count");
    end

    // ---------------- registers ----------------
    logic [7:0] port_h_wake_polarity, port_j_wake_polarity;
    logic [7:0] port_h_wake_irq_enable, port_j_wake_irq_enable;
    logic [7:0] next_pol_h, next_pol_j, next_ie_h, next_ie_j;
    logic [7:0] clr_h, clr_j;
    logic [7:0] port_h_wake_flags, port_j_wake_flags;
    logic       ack, next_ack;
    logic       err, next_err;
    logic [31:0] rdata, next_rdata;
    logic       req;
    logic       wr_lane0;
    logic       mapped;
    pin_pair_s  lvl;
    pin_pair_s  act;
    logic [7:0] gate_h, gate_j;

    assign req      = wb_cyc_i & wb_stb_i & ~ack & ~err;
    assign wr_lane0 = req & wb_we_i & wb_sel_i[0];

    always_comb begin
        case (wb_adr_i)
            OFS_H_FLAGS, OFS_J_FLAGS, OFS_H_POL, OFS_J_POL,
            OFS_H_IRQ_EN, OFS_J_IRQ_EN, OFS_H_PINS, OFS_J_PINS,
            OFS_FILT_STAT: mapped = 1'b1;
            default:       mapped = 1'b0;
        endcase
    end

    // ---------------- stop filter ----------------
    filt_state_e state, next_state;
    logic [$clog2(FILT_CYC+1)-1:0] cnt, next_cnt;
    logic [1:0] votes, next_votes;
    logic [1:0] samp, next_samp;
    logic       filt_ok, next_filt_ok;
    logic       trig_any;
    logic       prev_trig, next_prev_trig;
    localparam int SLOT = FILT_CYC / SAMPLES;

    // shared trigger: any enabled pin at its active level
    assign trig_any = |({act.h, act.j} &
                        {port_h_wake_irq_enable,
                         port_j_wake_irq_enable});

    always_comb begin
        next_state     = state;
        next_cnt       = cnt;
        next_votes     = votes;
        next_samp      = samp;
        next_filt_ok   = filt_ok;
        next_prev_trig = trig_any;
        if (!stop_mode_i) begin
            next_state   = FILT_IDLE;
            next_cnt     = '0;
            next_votes   = '0;
            next_samp    = '0;
            next_filt_ok = 1'b0;
        end else begin
            case (state)
                FILT_IDLE: begin
                    // oscillator runs only after an enabled edge
                    if (trig_any && !prev_trig) begin
                        next_state = FILT_VOTE;
                        next_cnt   = '0;
                        next_votes = '0;
                        next_samp  = '0;
                    end
                end
                FILT_VOTE: begin
                    next_cnt = cnt + 1'b1;
                    if (cnt == ($clog2(FILT_CYC+1))'(SLOT - 1)) begin
                        next_cnt  = '0;
                        next_samp = samp + 1'b1;
                        if (trig_any) begin
                            next_votes = votes + 1'b1;
                        end
                        if (samp == 2'(SAMPLES - 1)) begin
                            next_samp  = '0;
                            next_votes = '0;
                            // one low sample between pulses still passes
                            if ((votes + 2'(trig_any)) >=
                                2'(VOTE_MIN)) begin
                                next_filt_ok = 1'b1;
                                next_state   = FILT_HOLD;
                            end else begin
                                // short glitch dies here
                                next_state = FILT_IDLE;
                            end
                        end
                    end
                end
                FILT_HOLD: begin
                    if (!trig_any) begin
                        next_state = FILT_IDLE;
                    end
                end
                default: next_state = FILT_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state     <= FILT_IDLE;
            cnt       <= '0;
            votes     <= '0;
            samp      <= '0;
            filt_ok   <= 1'b0;
            prev_trig <= 1'b0;
        end else if (ce_i) begin
            state     <= next_state;
            cnt       <= next_cnt;
            votes     <= next_votes;
            samp      <= next_samp;
            filt_ok   <= next_filt_ok;
            prev_trig <= next_prev_trig;
        end
    end

    // in stop, flags only set once the filter accepted the pulse
    assign gate_h = (stop_mode_i && !filt_ok) ? 8'h00 : 8'hff;
    assign gate_j = gate_h;

    // ---------------- pins and flags ----------------
    kwu_pin_sync #(.W(NPINS)) u_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .ce_i    (ce_i),
        .async_i (wake_input_i),
        .level_o (lvl)
    );

    kwu_edge_flags #(.W(PORT_W)) u_flags_h (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .ce_i     (ce_i),
        .level_i  (lvl.h),
        .pol_i    (port_h_wake_polarity),
        .gate_i   (gate_h),
        .clr_i    (clr_h),
        .flags_o  (port_h_wake_flags),
        .active_o (act.h)
    );

    kwu_edge_flags #(.W(PORT_W)) u_flags_j (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .ce_i     (ce_i),
        .level_i  (lvl.j),
        .pol_i    (port_j_wake_polarity),
        .gate_i   (gate_j),
        .clr_i    (clr_j),
        .flags_o  (port_j_wake_flags),
        .active_o (act.j)
    );

    assign pull_up_en_o.h   = ~port_h_wake_polarity;
    assign pull_up_en_o.j   = ~port_j_wake_polarity;
    assign pull_down_en_o.h = port_h_wake_polarity;
    assign pull_down_en_o.j = port_j_wake_polarity;

    // ---------------- register file ----------------
    always_comb begin
        next_pol_h = port_h_wake_polarity;
        next_pol_j = port_j_wake_polarity;
        next_ie_h  = port_h_wake_irq_enable;
        next_ie_j  = port_j_wake_irq_enable;
        clr_h      = 8'h00;
        clr_j      = 8'h00;
        if (wr_lane0) begin
            case (wb_adr_i)
                OFS_H_FLAGS:  clr_h     = wb_dat_i[7:0];
                OFS_J_FLAGS:  clr_j     = wb_dat_i[7:0];
                OFS_H_POL:    next_pol_h = wb_dat_i[7:0];
                OFS_J_POL:    next_pol_j = wb_dat_i[7:0];
                OFS_H_IRQ_EN: next_ie_h  = wb_dat_i[7:0];
                OFS_J_IRQ_EN: next_ie_j  = wb_dat_i[7:0];
                default: ;
            endcase
        end
        next_ack   = req & mapped;
        next_err   = req & ~mapped;
        next_rdata = 32'h0000_0000;
        case (wb_adr_i)
            OFS_H_FLAGS:   next_rdata[7:0] = port_h_wake_flags;
            OFS_J_FLAGS:   next_rdata[7:0] = port_j_wake_flags;
            OFS_H_POL:     next_rdata[7:0] = port_h_wake_polarity;
            OFS_J_POL:     next_rdata[7:0] = port_j_wake_polarity;
            OFS_H_IRQ_EN:  next_rdata[7:0] = port_h_wake_irq_enable;
            OFS_J_IRQ_EN:  next_rdata[7:0] = port_j_wake_irq_enable;
            OFS_H_PINS:    next_rdata[7:0] = lvl.h;
            OFS_J_PINS:    next_rdata[7:0] = lvl.j;
            OFS_FILT_STAT: next_rdata[2:0] = {filt_ok, state};
            default:       next_rdata      = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            port_h_wake_polarity   <= RST_POL;
            port_j_wake_polarity   <= RST_POL;
            port_h_wake_irq_enable <= RST_IRQ_EN;
            port_j_wake_irq_enable <= RST_IRQ_EN;
            ack                    <= 1'b0;
            err                    <= 1'b0;
            rdata                  <= 32'h0000_0000;
        end else if (ce_i) begin
            port_h_wake_polarity   <= next_pol_h;
            port_j_wake_polarity   <= next_pol_j;
            port_h_wake_irq_enable <= next_ie_h;
            port_j_wake_irq_enable <= next_ie_j;
            ack                    <= next_ack;
            err                    <= next_err;
            rdata                  <= next_rdata;
        end
    end

    assign wb_ack_o = ack;
    assign wb_err_o = err;
    assign wb_dat_o = rdata;

    // one shared request for all sixteen pins
    assign irq_o = |({port_h_wake_flags, port_j_wake_flags} &
                     {port_h_wake_irq_enable,
                      port_j_wake_irq_enable});

    // raw pin straight to the wake request, no flop on the way;
    // works while the clock is stopped
    assign stop_wake_o = stop_mode_i &
        |(~(wake_input_i ^ {port_h_wake_polarity, port_j_wake_polarity})
          & {port_h_wake_irq_enable, port_j_wake_irq_enable});
endmodule
`default_nettype wire

// ===== tb/kwu_monitor.sv
// port checker for the key wake-up block
`timescale 1ns/1ps
`default_nettype none
module kwu_monitor
    import kwu_pkg::*;
#(
    parameter int FILT_CYC = 3
) (
    // clock and reset
    input wire logic               clk_i,
    input wire logic               rst_i,
    input wire logic               ce_i,
    // wishbone
    input wire logic               wb_cyc_i,
    input wire logic               wb_stb_i,
    input wire logic               wb_we_i,
    input wire logic [7:0]         wb_adr_i,
    input wire logic [3:0]         wb_sel_i,
    input wire logic [31:0]        wb_dat_i,
    input wire logic [31:0]        wb_dat_o,
    input wire logic               wb_ack_o,
    input wire logic               wb_err_o,
    // pins and wake
    input wire kwu_pkg::pin_pair_s wake_input_i,
    input wire kwu_pkg::pin_pair_s pull_up_en_o,
    input wire kwu_pkg::pin_pair_s pull_down_en_o,
    input wire logic               stop_mode_i,
    input wire logic               irq_o,
    input wire logic               stop_wake_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    AST_PULL_COMPL: assert property (pull_up_en_o == ~pull_down_en_o)
        else $error("pull enables not complementary");
    AST_PULL_RST: assert property ($past(rst_i) |-> pull_up_en_o == 16'hffff)
        else $error("pull-ups not all on after reset");
    AST_PULL_WR: assert property (!$stable(pull_down_en_o) |-> wb_ack_o && wb_we_i)
        else $error("pull enables moved without a write");
    AST_ACK_TIME: assert property (ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o
        && !wb_err_o |=> wb_ack_o ^ wb_err_o)
        else $error("bus answer missing one cycle after request");
    AST_IRQ_RST: assert property ($past(rst_i) |-> !irq_o)
        else $error("interrupt high straight after reset");
    AST_IRQ_FALL: assert property ($fell(irq_o) |-> wb_ack_o && wb_we_i)
        else $error("interrupt dropped without a write");
    AST_STOP_ONLY: assert property (!stop_mode_i |-> !stop_wake_o)
        else $error("stop wake outside stop mode");
    AST_WAKE_IDLE: assert property (wake_input_i == pull_up_en_o |-> !stop_wake_o)
        else $error("stop wake with all pins inactive");
    AST_RDATA_HI: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0)
        else $error("upper read data not zero");
endmodule

bind key_wakeup_edge_detect kwu_monitor #(.FILT_CYC(FILT_CYC)) mon (
    .clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .wake_input_i,
    .pull_up_en_o, .pull_down_en_o, .stop_mode_i, .irq_o, .stop_wake_o
);
`default_nettype wire

// ===== tb/kwu_keys.sv
// key switches and pull network in front of the wake-up pins
`timescale 1ns/1ps
`default_nettype none
module kwu_keys (
    // pull network from the block
    input  wire kwu_pkg::pin_pair_s pull_up_i,
    input  wire kwu_pkg::pin_pair_s pull_down_i,
    // key closures
    input  wire logic [15:0]        press_i,
    // pin levels
    output var kwu_pkg::pin_pair_s  pins_o
);
    import kwu_pkg::*;
    // a closed key shorts the pin to the rail opposite its pull
    assign pins_o = (press_i & pull_down_i)
        | (~press_i & (pull_up_i | ~pull_down_i));
endmodule
`default_nettype wire

// ===== tb/testbench.sv
// register-level testbench for the key wake-up block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import kwu_pkg::*;
    localparam int FC = 6;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] dat = 32'h0;
    logic [31:0] rdat;
    logic        ack;
    logic        err;
    logic        stop = 1'b0;
    logic [15:0] press = 16'h0;
    logic        irq;
    logic        swake;
    pin_pair_s   pins;
    pin_pair_s   pu;
    pin_pair_s   pd;
    logic [7:0]  q;
    logic        e;
    int          mismatches = 0;
    int          compares = 0;

    always #5 clk_i = ~clk_i;

    key_wakeup_edge_detect #(.FILT_CYC(FC)) uut (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
        .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err),
        .wake_input_i(pins), .pull_up_en_o(pu), .pull_down_en_o(pd),
        .stop_mode_i(stop), .irq_o(irq), .stop_wake_o(swake));
    kwu_keys keys (.pull_up_i(pu), .pull_down_i(pd), .press_i(press),
        .pins_o(pins));

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // hold the request until ack or err is seen at an edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= {24'h0, d};
        // no cycle count assumed; only the watchdog ends a hung wait
        do begin
            @(posedge clk_i);
        end while (!(ack || err));
        q = rdat[7:0];
        e = err;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] x);
        bus(1'b0, a, 8'h00);
        check(e, 1'b0);
        check(q, x);
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        tick(20000);
        mismatches++;
        tally_and_finish();
    end

    initial begin
        tick(12);
        rst_i <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            rd(8'(i * 4), 8'h00);
        end
        check(pu, 16'hffff);
        check(irq, 1'b0);
        bus(1'b0, 8'h24, 8'h00);
        check(e, 1'b1);
        $display("test reset done");
        // polarity first, then flags, as software must
        bus(1'b1, OFS_H_POL, 8'h02);
        rd(OFS_H_POL, 8'h02);
        check(pd, 16'h0200);
        check(pu, 16'hfdff);
        tick(8);
        bus(1'b1, OFS_H_FLAGS, 8'hff);
        rd(OFS_H_FLAGS, 8'h00);
        press <= 16'h0300;
        tick(8);
        rd(OFS_H_FLAGS, 8'h03);
        press <= 16'h0000;
        tick(8);
        rd(OFS_H_FLAGS, 8'h03);
        check(irq, 1'b0);
        bus(1'b1, OFS_H_IRQ_EN, 8'h01);
        check(irq, 1'b1);
        bus(1'b1, OFS_H_FLAGS, 8'h02);
        rd(OFS_H_FLAGS, 8'h01);
        check(irq, 1'b1);
        bus(1'b1, OFS_H_FLAGS, 8'h01);
        check(irq, 1'b0);
        $display("test port h done");
        bus(1'b1, OFS_J_POL, 8'h80);
        tick(8);
        bus(1'b1, OFS_J_FLAGS, 8'hff);
        bus(1'b1, OFS_J_IRQ_EN, 8'h80);
        press <= 16'h0080;
        tick(8);
        check(irq, 1'b1);
        rd(OFS_J_FLAGS, 8'h80);
        press <= 16'h0000;
        bus(1'b1, OFS_J_FLAGS, 8'h80);
        check(irq, 1'b0);
        $display("test port j done");
        // stop mode: disabled pin, glitch, then a held key
        stop <= 1'b1;
        press <= 16'h0400;
        tick(FC * 4);
        check(swake, 1'b0);
        bus(1'b0, OFS_FILT_STAT, 8'h00);
        check(q[2:0], 3'h0);
        press <= 16'h0100;
        tick(1);
        press <= 16'h0000;
        check(swake, 1'b1);
        tick(FC * 4);
        bus(1'b0, OFS_FILT_STAT, 8'h00);
        check(q[2], 1'b0);
        press <= 16'h0100;
        tick(FC * 4);
        check(swake, 1'b1);
        bus(1'b0, OFS_FILT_STAT, 8'h00);
        check(q[2], 1'b1);
        rd(OFS_H_FLAGS, 8'h01);
        press <= 16'h0000;
        stop <= 1'b0;
        tick(FC * 4);
        $display("test stop filter done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
